// ===== hdl/gpc_params.svh
// gpc_params.svh: addresses, field positions, reset values and the key of the
// guarded gpio configuration block.
// assumes a single 32-bit aligned word per register on an ahb-lite bus.
`ifndef GPC_PARAMS_SVH
`define GPC_PARAMS_SVH

// ***************************************************************************
// register byte addresses
// ***************************************************************************
`define GPC_BASE_LO          16'h0E00
`define GPC_ADR_EDGE_LEVEL   32'h400E_0EC8
`define GPC_ADR_POLARITY     32'h400E_0ED8
`define GPC_ADR_LOCK         32'h400E_0EE0
`define GPC_ADR_GUARD_MODE   32'h400E_0EE4
`define GPC_ADR_GUARD_STAT   32'h400E_0EE8
`define GPC_ADR_HYSTERESIS   32'h400E_0F00
`define GPC_ADR_PAD_DELAY    32'h400E_0F10
`define GPC_ADR_CAP_MODE     32'h400E_0F50
`define GPC_ADR_CAP_HOLD     32'h400E_0F64
`define GPC_ADR_IRQ_STAT     32'h400E_0F80
`define GPC_ADR_IRQ_MASK     32'h400E_0F84

// ***************************************************************************
// field positions and key
// ***************************************************************************
`define GPC_KEY_VALUE        24'h50_494F
`define GPC_CAP_EN_BIT       0
`define GPC_CAP_WIDTH_LO     4
`define GPC_CAP_IGNORE_BIT   9
`define GPC_CAP_HALF_BIT     10
`define GPC_CAP_ODD_BIT      11
`define GPC_IRQ_VIOL_BIT     0
`define GPC_IRQ_READY_BIT    1
`define GPC_IRQ_OVERRUN_BIT  2

// ***************************************************************************
// reset values
// ***************************************************************************
`define GPC_RST_HYSTERESIS   32'h0000_0000
`define GPC_RST_PAD_DELAY    32'h0000_0000
`define GPC_RST_IRQ_MASK     3'h0

`endif

// ===== hdl/gpc_pkg.sv
// gpc_pkg.sv: types shared by the guarded gpio configuration block.
// assumes gpc_params.svh supplies all numeric constants.
package gpc_pkg;

   // ************************************************************************
   // capture datum width encodings
   // ************************************************************************
   typedef enum logic [1:0] {
      GPC_WIDTH_BYTE = 2'b00,
      GPC_WIDTH_HALF = 2'b01,
      GPC_WIDTH_WORD = 2'b10,
      GPC_WIDTH_RSVD = 2'b11
   } gpc_width_t;

endpackage : gpc_pkg

// ===== hdl/gpc_capture_sampler.sv
// gpc_capture_sampler.sv: parallel capture front end, qualifies, decimates
// and packs pin bytes into words.
// assumes pins are asynchronous to clock_i and much slower than it.
`timescale 1ns/100ps
`default_nettype none

module gpc_capture_sampler (
   input  wire logic              clock_i,       // system clock
   input  wire logic              srst_i,        // sync reset, high
   input  wire logic              ce_i,          // clock enable
   input  wire logic              enable_i,      // capture enable
   input  wire gpc_pkg::gpc_width_t width_i,     // datum width
   input  wire logic              ignore_en_i,   // sample whatever enables
   input  wire logic              half_i,        // keep every other datum
   input  wire logic              odd_i,         // keep odd indexes
   input  wire logic [7:0]        pin_data_i,    // capture data pins
   input  wire logic              pin_den1_i,    // data enable 1 pin
   input  wire logic              pin_den2_i,    // data enable 2 pin
   input  wire logic              pin_clk_i,     // capture clock pin
   output logic      [31:0]       word_o,        // packed datum
   output logic                   word_valid_o   // one-cycle strobe
);

   logic [10:0] sync1;
   logic [10:0] sync2;
   logic        clk_d;
   logic        idx;
   logic [1:0]  cnt;
   logic [7:0]  lane [4];
   logic        qualified;
   logic        keep;
   logic        last;
   logic [31:0] next_word;

   // last lane index for a width; reserved packs as a full word
   function automatic logic [1:0] last_lane(input gpc_pkg::gpc_width_t w);
      unique case (w)
         gpc_pkg::GPC_WIDTH_BYTE: last_lane = 2'h0;
         gpc_pkg::GPC_WIDTH_HALF: last_lane = 2'h1;
         gpc_pkg::GPC_WIDTH_WORD: last_lane = 2'h3;
         gpc_pkg::GPC_WIDTH_RSVD: last_lane = 2'h3;
      endcase
   endfunction : last_lane

   // ************************************************************************
   // two-stage pin synchroniser
   // ************************************************************************
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         sync1 <= 11'h000;
         sync2 <= 11'h000;
         clk_d <= 1'b0;
      end else if (ce_i) begin
         sync1 <= {pin_clk_i, pin_den2_i, pin_den1_i, pin_data_i};
         sync2 <= sync1;
         clk_d <= sync2[10];
      end
   end

   // rising capture clock, gated by enable and, unless ignore_en_i is set, by both data enables
   assign qualified = sync2[10] && !clk_d && enable_i
                      && (ignore_en_i || (sync2[8] && sync2[9]));
   // decimation applies to qualified data only
   assign keep = qualified && (!half_i || (idx == odd_i));
   assign last = (cnt == last_lane(width_i));

   // ************************************************************************
   // arrival index and lane counter, both restart when capture is off
   // ************************************************************************
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         idx <= 1'b0;
         cnt <= 2'h0;
      end else if (ce_i) begin
         // the restart waits for the clock enable too, so a frozen block keeps its place
         if (!enable_i) begin
            idx <= 1'b0;
            cnt <= 2'h0;
         end else begin
            if (qualified) begin
               idx <= !idx;
            end
            if (keep) begin
               cnt <= last ? 2'h0 : cnt + 2'h1;
            end
         end
      end
   end

   // ************************************************************************
   // byte lanes, low byte first; lanes above the width read as zero
   // ************************************************************************
   for (genvar i = 0; i < 4; i++) begin : g_lane
      always_ff @(posedge clock_i) begin
         if (srst_i) begin
            lane[i] <= 8'h00;
         end else if (ce_i && keep && cnt == 2'(i)) begin
            lane[i] <= sync2[7:0];
         end
      end
      assign next_word[8*i +: 8] = (2'(i) > last_lane(width_i)) ? 8'h00 :
                                   (cnt == 2'(i)) ? sync2[7:0] : lane[i];
   end

   // word strobe on the last lane of a datum
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         word_o       <= 32'h0000_0000;
         word_valid_o <= 1'b0;
      end else if (ce_i) begin
         word_valid_o <= keep && last;
         if (keep && last) begin
            word_o <= next_word;
         end
      end
   end

   property p_half_skip;
      @(posedge clock_i) disable iff (srst_i)
      (ce_i && qualified && half_i && (idx != odd_i)) |=> (cnt == $past(cnt));
   endproperty
   a_half_skip: assert property (p_half_skip) else $error("skipped datum was packed");

endmodule : gpc_capture_sampler

`default_nettype wire

// ===== hdl/gpc_gpio_guard.sv
// gpc_gpio_guard.sv: guarded gpio configuration block with line status,
// key-guarded write protection, pad settings and parallel capture.
// assumes one ahb-lite master with this slave's hreadyout as hready.
//
// Overview of operation
// - report per-line interrupt polarity status
// - report per-line lock status, read only
// - key plus one turns protection on
// - key plus zero turns protection off
// - wrong key leaves protection bit unchanged
// - key field always reads zero
// - violation flag set, cleared by status read
// - violation offset shown in bits 8-23
// - capture mode writes refused while protected
// - hysteresis bit zero enables, one disables
// - eight 4-bit pad delay fields
// - capture runs only while enable set
// - width field selects 8/16/32 bit data
// - sample only when both enables active, unless enables ignored
// - half sampling keeps every other datum
// - odd select picks even or odd data
// - edge/level status, edge zero level one
// - data ready clears on read or disable
`timescale 1ns/100ps
`default_nettype none
`include "gpc_params.svh"

module gpc_gpio_guard (
   input  wire logic        clock_i,            // system clock, 250 MHz
   input  wire logic        srst_i,             // sync reset, high
   input  wire logic        ce_i,               // clock enable, freezes all
   input  wire logic        hsel_i,             // ahb slave select
   input  wire logic [31:0] haddr_i,            // ahb address
   input  wire logic [1:0]  htrans_i,           // ahb transfer type
   input  wire logic        hwrite_i,           // ahb write
   input  wire logic [2:0]  hsize_i,            // ahb size, words only
   input  wire logic [31:0] hwdata_i,           // ahb write data
   input  wire logic        hready_i,           // ahb bus ready
   output logic      [31:0] hrdata_o,           // ahb read data
   output logic             hreadyout_o,        // ahb slave ready
   output logic             hresp_o,            // ahb response, okay
   input  wire logic [31:0] line_edge_level_i,  // per-line edge/level mode
   input  wire logic [31:0] line_polarity_i,    // per-line polarity mode
   input  wire logic [31:0] line_lock_i,        // per-line lock state
   input  wire logic [7:0]  cap_data_i,         // capture data pins
   input  wire logic        cap_den1_i,         // capture data enable 1
   input  wire logic        cap_den2_i,         // capture data enable 2
   input  wire logic        cap_clk_i,          // capture clock pin
   output logic      [31:0] hysteresis_disable_o, // per-line disable
   output logic      [31:0] pad_delay_o,        // eight 4-bit delays
   output logic             guard_enable_o,     // protection active
   output logic             capture_enable_o,   // capture running
   output logic      [1:0]  capture_width_o,    // capture datum width
   output logic             irq_o               // level interrupt
);

   // ************************************************************************
   // declarations
   // ************************************************************************
   logic        dph_valid;     // data phase pending
   logic        dph_write;
   logic [31:0] dph_addr;
   logic        rd_wait;       // read wait cycle
   logic        wr_apply;
   logic        rd_load;
   logic        guard_violation_flag;
   logic [15:0] guard_violation_offset;
   logic [11:0] cap_cfg;
   logic [31:0] capture_holding;
   logic        capture_data_ready;
   logic [2:0]  irq_status;
   logic [2:0]  irq_mask;
   logic [31:0] rd_value;
   logic        key_ok;
   logic        viol_event;
   logic [31:0] cap_word;
   logic        cap_word_valid;

   // registers that only unguarded writes may change
   function automatic logic is_protected(input logic [31:0] a);
      is_protected = (a == `GPC_ADR_CAP_MODE) || (a == `GPC_ADR_HYSTERESIS)
                     || (a == `GPC_ADR_PAD_DELAY);
   endfunction : is_protected

   // ************************************************************************
   // ahb-lite slave: reads take one wait state so hrdata comes from a flop
   // ************************************************************************
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         dph_valid   <= 1'b0;
         dph_write   <= 1'b0;
         dph_addr    <= 32'h0000_0000;
         rd_wait     <= 1'b0;
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
      end else if (ce_i) begin
         hresp_o <= 1'b0;
         if (rd_wait) begin
            rd_wait     <= 1'b0;
            hreadyout_o <= 1'b1;
            dph_valid   <= 1'b0;
         end else if (hready_i) begin
            dph_valid   <= hsel_i && htrans_i[1];
            dph_write   <= hwrite_i;
            dph_addr    <= haddr_i;
            rd_wait     <= hsel_i && htrans_i[1] && !hwrite_i;
            hreadyout_o <= !(hsel_i && htrans_i[1] && !hwrite_i);
         end
      end
   end

   // write data stands in the cycle after the address phase
   assign wr_apply = dph_valid && dph_write && hreadyout_o;
   assign rd_load  = rd_wait;
   assign key_ok   = (hwdata_i[31:8] == `GPC_KEY_VALUE);
   assign viol_event = wr_apply && guard_enable_o && is_protected(dph_addr);

   // ************************************************************************
   // read multiplexer; unmapped addresses read as zero
   // ************************************************************************
   always_comb begin
      rd_value = 32'h0000_0000;
      unique case (dph_addr)
         `GPC_ADR_EDGE_LEVEL: rd_value = line_edge_level_i;
         `GPC_ADR_POLARITY:   rd_value = line_polarity_i;
         `GPC_ADR_LOCK:       rd_value = line_lock_i;
         `GPC_ADR_GUARD_MODE: rd_value = {24'h00_0000, 7'h00, guard_enable_o};
         `GPC_ADR_GUARD_STAT: rd_value = {8'h00, guard_violation_offset,
                                          7'h00, guard_violation_flag};
         `GPC_ADR_HYSTERESIS: rd_value = hysteresis_disable_o;
         `GPC_ADR_PAD_DELAY:  rd_value = pad_delay_o;
         `GPC_ADR_CAP_MODE:   rd_value = {20'h0_0000, cap_cfg};
         `GPC_ADR_CAP_HOLD:   rd_value = capture_holding;
         `GPC_ADR_IRQ_STAT:   rd_value = {29'h0000_0000, irq_status};
         `GPC_ADR_IRQ_MASK:   rd_value = {29'h0000_0000, irq_mask};
         default:             rd_value = 32'h0000_0000;
      endcase
   end

   // read data register, loaded in the wait cycle
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         hrdata_o <= 32'h0000_0000;
      end else if (ce_i && rd_load) begin
         hrdata_o <= rd_value;
      end
   end

   // ************************************************************************
   // write guard: the enable bit changes only with the right key
   // ************************************************************************
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         guard_enable_o <= 1'b0;
      end else if (ce_i && wr_apply && dph_addr == `GPC_ADR_GUARD_MODE && key_ok) begin
         guard_enable_o <= hwdata_i[0];
      end
   end

   // violation flag and source; a new violation wins over the read clear
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         guard_violation_flag   <= 1'b0;
         guard_violation_offset <= 16'h0000;
      end else if (ce_i) begin
         if (viol_event) begin
            guard_violation_flag   <= 1'b1;
            guard_violation_offset <= dph_addr[15:0] - `GPC_BASE_LO;
         end else if (rd_load && dph_addr == `GPC_ADR_GUARD_STAT) begin
            guard_violation_flag <= 1'b0;
         end
      end
   end

   // ************************************************************************
   // guarded configuration registers
   // ************************************************************************
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         hysteresis_disable_o <= `GPC_RST_HYSTERESIS;
         pad_delay_o          <= `GPC_RST_PAD_DELAY;
      end else if (ce_i && wr_apply && !guard_enable_o) begin
         if (dph_addr == `GPC_ADR_HYSTERESIS) begin
            hysteresis_disable_o <= hwdata_i;
         end
         if (dph_addr == `GPC_ADR_PAD_DELAY) begin
            pad_delay_o <= hwdata_i;
         end
      end
   end

   // capture mode keeps only its defined bits
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         cap_cfg <= 12'h000;
      end else if (ce_i && wr_apply && !guard_enable_o && dph_addr == `GPC_ADR_CAP_MODE) begin
         cap_cfg <= hwdata_i[11:0] & 12'hE31;
      end
   end

   assign capture_enable_o = cap_cfg[`GPC_CAP_EN_BIT];
   assign capture_width_o  = cap_cfg[`GPC_CAP_WIDTH_LO +: 2];

   // ************************************************************************
   // capture front end
   // ************************************************************************
   gpc_capture_sampler u_sampler (
      .clock_i      (clock_i),
      .srst_i       (srst_i),
      .ce_i         (ce_i),
      .enable_i     (cap_cfg[`GPC_CAP_EN_BIT]),
      .width_i      (gpc_pkg::gpc_width_t'(cap_cfg[`GPC_CAP_WIDTH_LO +: 2])),
      .ignore_en_i  (cap_cfg[`GPC_CAP_IGNORE_BIT]),
      .half_i       (cap_cfg[`GPC_CAP_HALF_BIT]),
      .odd_i        (cap_cfg[`GPC_CAP_ODD_BIT]),
      .pin_data_i   (cap_data_i),
      .pin_den1_i   (cap_den1_i),
      .pin_den2_i   (cap_den2_i),
      .pin_clk_i    (cap_clk_i),
      .word_o       (cap_word),
      .word_valid_o (cap_word_valid)
   );

   // holding register and ready flag; a new word wins over the read clear
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         capture_holding    <= 32'h0000_0000;
         capture_data_ready <= 1'b0;
      end else if (ce_i) begin
         if (cap_word_valid && cap_cfg[`GPC_CAP_EN_BIT]) begin
            capture_holding    <= cap_word;
            capture_data_ready <= 1'b1;
         end else if (!cap_cfg[`GPC_CAP_EN_BIT]
                      || (rd_load && dph_addr == `GPC_ADR_CAP_HOLD)) begin
            capture_data_ready <= 1'b0;
         end
      end
   end

   // ************************************************************************
   // interrupts: sticky status, write one to clear, set wins
   // ************************************************************************
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         irq_status <= 3'h0;
         irq_mask   <= `GPC_RST_IRQ_MASK;
         irq_o      <= 1'b0;
      end else if (ce_i) begin
         irq_status <= (irq_status
                        & ~((wr_apply && dph_addr == `GPC_ADR_IRQ_STAT) ? hwdata_i[2:0] : 3'h0))
                       | {cap_word_valid && capture_data_ready,
                          cap_word_valid,
                          viol_event};
         if (wr_apply && dph_addr == `GPC_ADR_IRQ_MASK) begin
            irq_mask <= hwdata_i[2:0];
         end
         // one cycle behind the status so the output is a flop
         irq_o <= |(irq_status & irq_mask);
      end
   end

   // ************************************************************************
   // assertions
   // ************************************************************************
   sequence s_read_wait;
      !hreadyout_o ##1 hreadyout_o;
   endsequence

   property p_read_wait;
      @(posedge clock_i) disable iff (srst_i || !ce_i)
      (hready_i && hsel_i && htrans_i[1] && !hwrite_i) |=> s_read_wait;
   endproperty
   a_read_wait: assert property (p_read_wait) else $error("read answer not one wait state");

   property p_guard_on;
      @(posedge clock_i) disable iff (srst_i)
      (ce_i && wr_apply && dph_addr == `GPC_ADR_GUARD_MODE && key_ok && hwdata_i[0])
      |=> guard_enable_o;
   endproperty
   a_guard_on: assert property (p_guard_on) else $error("keyed enable not taken");

   property p_guard_off;
      @(posedge clock_i) disable iff (srst_i)
      (ce_i && wr_apply && dph_addr == `GPC_ADR_GUARD_MODE && key_ok && !hwdata_i[0])
      |=> !guard_enable_o;
   endproperty
   a_guard_off: assert property (p_guard_off) else $error("keyed disable not taken");

   property p_bad_key;
      @(posedge clock_i) disable iff (srst_i)
      (wr_apply && dph_addr == `GPC_ADR_GUARD_MODE && !key_ok) |=> $stable(guard_enable_o);
   endproperty
   a_bad_key: assert property (p_bad_key) else $error("wrong key changed guard");

   property p_key_zero;
      @(posedge clock_i) disable iff (srst_i)
      (ce_i && rd_load && dph_addr == `GPC_ADR_GUARD_MODE) |=> (hrdata_o[31:8] == 24'h00_0000);
   endproperty
   a_key_zero: assert property (p_key_zero) else $error("key field read nonzero");

   sequence s_viol_reported;
      guard_violation_flag && (guard_violation_offset == $past(dph_addr[15:0]) - `GPC_BASE_LO);
   endsequence

   property p_viol;
      @(posedge clock_i) disable iff (srst_i)
      (ce_i && viol_event) |=> s_viol_reported;
   endproperty
   a_viol: assert property (p_viol) else $error("violation not reported");

   property p_stat_clear;
      @(posedge clock_i) disable iff (srst_i)
      (ce_i && rd_load && dph_addr == `GPC_ADR_GUARD_STAT && !viol_event)
      |=> !guard_violation_flag ##1 (hrdata_o[0] == $past(guard_violation_flag, 2));
   endproperty
   a_stat_clear: assert property (p_stat_clear) else $error("status read did not clear");

   property p_cap_locked;
      @(posedge clock_i) disable iff (srst_i)
      (wr_apply && guard_enable_o && dph_addr == `GPC_ADR_CAP_MODE) |=> $stable(cap_cfg);
   endproperty
   a_cap_locked: assert property (p_cap_locked) else $error("guarded capture mode written");

   property p_ready_off;
      @(posedge clock_i) disable iff (srst_i)
      (ce_i && !capture_enable_o) |=> !capture_data_ready;
   endproperty
   a_ready_off: assert property (p_ready_off) else $error("ready kept while disabled");

   // a refused write leaves every guarded register as it was
   property p_guard_hold;
      @(posedge clock_i) disable iff (srst_i)
      (ce_i && viol_event)
      |=> ($stable(hysteresis_disable_o) && $stable(pad_delay_o) && $stable(cap_cfg));
   endproperty
   a_guard_hold: assert property (p_guard_hold) else $error("guarded register written");

   // interrupt output follows the masked status one cycle later
   property p_irq_level;
      @(posedge clock_i) disable iff (srst_i)
      ce_i |=> (irq_o == |($past(irq_status) & $past(irq_mask)));
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

endmodule : gpc_gpio_guard

`default_nettype wire

// ===== verification/gpc_pix_src.sv
// gpc_pix_src.sv: parallel pixel source that drives the capture pins.
// assumes clock_i is the system clock; pin clock idles low between bytes.
`timescale 1ns/100ps
`default_nettype none
module gpc_pix_src (
   input  wire logic       clock_i, // system clock
   output logic      [7:0] data_o,  // capture data
   output logic            den1_o,  // data enable 1
   output logic            den2_o,  // data enable 2
   output logic            clk_o    // pin clock
);
   initial {data_o, den1_o, den2_o, clk_o} = '0;
   // one byte, 4 clocks high and low; lines flip after hold so stale data never passes
   task send(input logic [7:0] b, input logic en);
      @(posedge clock_i);
      data_o <= b;
      den1_o <= en;
      den2_o <= en;
      repeat (4) @(posedge clock_i);
      clk_o <= 1'b1;
      repeat (4) @(posedge clock_i);
      clk_o  <= 1'b0;
      data_o <= ~b;
      den1_o <= ~en;
      den2_o <= ~en;
   endtask : send
endmodule : gpc_pix_src
`default_nettype wire

// ===== verification/tb_top.sv
// tb_top.sv: self-checking bench of the guarded gpio block.
// assumes the ahb slave is alone, so its hreadyout is hready.
`timescale 1ns/100ps
`default_nettype none
`include "gpc_params.svh"
module tb_top;
   logic clock_i = 0, srst_i = 1, hwrite = 0;
   logic [1:0] htrans = 0;
   logic [31:0] haddr = 0, hwdata = 0, q, r, el = 0, pol = 0, lk = 0, hrd, hys, pad;
   logic [7:0] b [4];
   logic [7:0] cd;
   logic rdy, hresp, ge, ce, irq, d1, d2, ck_p;
   logic [1:0] cw;
   int failures = 0, samples_checked = 0, n;
   always #2 clock_i = ~clock_i;
   gpc_pix_src i_src (.clock_i(clock_i), .data_o(cd), .den1_o(d1), .den2_o(d2), .clk_o(ck_p));
   gpc_gpio_guard i_dut (.clock_i(clock_i), .srst_i(srst_i), .ce_i(1'b1), .hsel_i(1'b1),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
      .hready_i(rdy), .hrdata_o(hrd), .hreadyout_o(rdy), .hresp_o(hresp),
      .line_edge_level_i(el), .line_polarity_i(pol), .line_lock_i(lk), .cap_data_i(cd),
      .cap_den1_i(d1), .cap_den2_i(d2), .cap_clk_i(ck_p), .hysteresis_disable_o(hys),
      .pad_delay_o(pad), .guard_enable_o(ge), .capture_enable_o(ce), .capture_width_o(cw),
      .irq_o(irq));
   // expected guard status after a refused write at byte address a
   function automatic logic [31:0] vs(input logic [31:0] a);
      return {8'h00, a[15:0] - `GPC_BASE_LO, 8'h01};
   endfunction : vs
   task summarize;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : summarize
   task ck(input string s, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s exp %h got %h", s, e, g);
      end
   endtask : ck
   // bounded wait for hready at a rising edge
   task wt;
      n = 0;
      do begin @(posedge clock_i); n++; end while (rdy !== 1'b1 && n < 50);
      if (n >= 50) begin failures++; summarize(); end
   endtask : wt
   // one single word transfer, read data left in q
   task rw(input logic w, input logic [31:0] a, input logic [31:0] d);
      haddr <= a; hwrite <= w; htrans <= 2'b10;
      wt();
      htrans <= 2'b00; hwdata <= d;
      wt();
      q = hrd;
      // a write lands at this edge; one more edge lets the outputs show it
      if (w) @(posedge clock_i);
   endtask : rw
   initial begin
      void'($urandom(32'hcf58));
      repeat (5) @(posedge clock_i);
      srst_i <= 0;
      @(posedge clock_i);
      el <= $urandom; pol <= $urandom; lk <= $urandom;
      rw(0, `GPC_ADR_HYSTERESIS, 0); ck("hys_rst", `GPC_RST_HYSTERESIS, q);
      r = $urandom; rw(1, `GPC_ADR_HYSTERESIS, r); rw(0, `GPC_ADR_HYSTERESIS, 0);
      ck("hys", r, q); ck("hys_o", r, hys);
      r = $urandom; rw(1, `GPC_ADR_PAD_DELAY, r); rw(0, `GPC_ADR_PAD_DELAY, 0);
      ck("pad", r, q); ck("pad_o", r, pad);
      rw(0, `GPC_ADR_POLARITY, 0); ck("pol", pol, q);
      rw(0, `GPC_ADR_LOCK, 0); ck("lock", lk, q);
      rw(0, `GPC_ADR_EDGE_LEVEL, 0); ck("edge", el, q);
      rw(1, `GPC_ADR_GUARD_MODE, 32'h1234_5601); ck("bad_key", 0, ge);
      rw(1, `GPC_ADR_GUARD_MODE, {`GPC_KEY_VALUE, 8'h01}); ck("g_on", 1, ge);
      rw(0, `GPC_ADR_GUARD_MODE, 0); ck("g_rd", 1, q);
      rw(1, `GPC_ADR_PAD_DELAY, ~r); ck("pad_lock", r, pad);
      rw(1, `GPC_ADR_CAP_MODE, 1); ck("cap_lock", 0, ce);
      rw(0, `GPC_ADR_GUARD_STAT, 0); ck("viol", vs(`GPC_ADR_CAP_MODE), q);
      rw(0, `GPC_ADR_GUARD_STAT, 0); ck("viol_clr", vs(`GPC_ADR_CAP_MODE) & ~32'h1, q);
      rw(1, `GPC_ADR_GUARD_MODE, {`GPC_KEY_VALUE, 8'h00}); ck("g_off", 0, ge);
      // half width, half rate, odd data kept, enables honoured
      rw(1, `GPC_ADR_IRQ_MASK, 32'h2);
      rw(1, `GPC_ADR_CAP_MODE, 32'h0000_0C11); ck("cap_w", 1, cw);
      i_src.send(8'hA5, 0);
      for (int i = 0; i < 4; i++) begin b[i] = $urandom; i_src.send(b[i], 1); end
      n = 0;
      while (irq !== 1'b1 && n < 100) begin @(posedge clock_i); n++; end
      ck("irq", 1, irq);
      if (n >= 100) summarize();
      rw(0, `GPC_ADR_CAP_HOLD, 0); ck("hold", {16'h0, b[3], b[1]}, q);
      rw(1, `GPC_ADR_IRQ_STAT, 32'h2);
      repeat (2) @(posedge clock_i);
      ck("irq_clr", 0, irq);
      rw(1, `GPC_ADR_CAP_MODE, 0); ck("cap_off", 0, ce);
      i_src.send(8'h3C, 1);
      repeat (10) @(posedge clock_i);
      rw(0, `GPC_ADR_IRQ_STAT, 0); ck("no_cap", 0, q & 32'h2);
      // word width, enables ignored, even data kept
      rw(1, `GPC_ADR_CAP_MODE, 32'h0000_0621); ck("cap_w2", 2, cw);
      for (int i = 0; i < 8; i++) begin
         b[0] = $urandom;
         i_src.send(b[0], 0);
         if (i % 2 == 0) r[4*i +: 8] = b[0];
      end
      rw(0, `GPC_ADR_CAP_HOLD, 0); ck("hold_w", r, q);
      ck("hresp", 0, hresp);
      summarize();
   end
endmodule : tb_top
`default_nettype wire
